//--- logic/pxt_pkg.sv
/*
  Shared constants for the external trigger and emergency stop control of a
  16-bit PWM pair: register offsets, field positions, reset values, timing.
  Assumes a 125 MHz MCLK and a 32-bit APB register bus.
*/
package pxt_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_PERIOD_PS = 8000;
  localparam int FAST_SAMPLE_PS = 125000;
  localparam int SLOW_SAMPLE_PS = 30500000;
  // Both figures round down, never below one cycle
  localparam int FAST_SAMPLE_CYC = (FAST_SAMPLE_PS / MCLK_PERIOD_PS) < 1 ?
    1 : (FAST_SAMPLE_PS / MCLK_PERIOD_PS);
  localparam int SLOW_SAMPLE_CYC = (SLOW_SAMPLE_PS / MCLK_PERIOD_PS) < 1 ?
    1 : (SLOW_SAMPLE_PS / MCLK_PERIOD_PS);
  localparam int TICK_W = 12;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DUTY_OFS = 8'h04;
  localparam logic [7:0] PERIOD_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] SDFLAG_OFS = 8'h10;
  localparam logic [7:0] BUF_OFS = 8'h14;

  // Control register fields
  localparam int RUN_BIT = 0;
  localparam int COUPLED_BIT = 1;
  localparam int CLK_SRC_LSB = 2;
  localparam int TRIG_MODE_LSB = 4;
  localparam int TRIG_SEL_BIT = 6;
  localparam int TRIG_POL_LSB = 7;
  localparam int CLR_INH_BIT = 9;
  localparam int SD_EDGE_LSB = 10;
  localparam int CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;

  // Status and shutdown flag register fields
  localparam int ST_FLAG_BIT = 16;
  localparam int ST_RUNNING_BIT = 17;
  localparam int SD_FLAG_BIT = 0;

  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hffff;

  // Encodings
  localparam logic [1:0] CLK_SRC_FAST = 2'b01;
  localparam logic [1:0] MODE_SW = 2'b00;
  localparam logic [1:0] MODE_SW_EXT = 2'b01;
  localparam logic [1:0] MODE_EXT = 2'b10;
  localparam logic [1:0] MODE_CLR = 2'b11;
  localparam logic [1:0] POL_RISE = 2'b01;
  localparam logic [1:0] POL_FALL = 2'b10;
  localparam logic [1:0] SD_FALL = 2'b01;
  localparam logic [1:0] SD_RISE = 2'b10;
  localparam logic [1:0] SD_BOTH = 2'b11;
endpackage

//--- logic/pxt_filter.sv
/*
  Pin synchroniser and sampling noise filter for one trigger input.
  Assumes tick is a one-cycle pulse at the chosen sampling rate.
*/
`timescale 1ns/1ps
module pxt_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic tick,
  output logic level_q,
  output logic rise_q,
  output logic fall_q
);
  logic meta_q;
  logic sync_q;
  logic smp_q;
  logic accept;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  // A new level is taken only when two samples agree
  assign accept = tick && (smp_q == sync_q) && (sync_q != level_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smp_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      if (tick) begin
        smp_q <= sync_q;
      end
      if (accept) begin
        level_q <= sync_q;
      end
      rise_q <= accept && sync_q;
      fall_q <= accept && !sync_q;
    end
  end

  AST_FILT_TICK: assert property (@(posedge clk) disable iff (rst)
    (level_q != $past(level_q)) |-> $past(tick, 1))
    else $error("Filtered level changed without a sampling tick");
endmodule // pxt_filter

//--- logic/pxt_buf.sv
/*
  Duty and period buffers reloaded from their registers.
  Assumes reload is a one-cycle pulse; a reload that meets a register
  write in the same cycle is carried one cycle later.
*/
`timescale 1ns/1ps
module pxt_buf (
  input wire logic clk,
  input wire logic rst,
  input wire logic reload,
  input wire logic reg_wr,
  input wire logic [15:0] duty_reg,
  input wire logic [15:0] period_reg,
  output logic [15:0] duty_buffer_q,
  output logic [15:0] period_buffer_q
);
  import pxt_pkg::*;
  logic pend_q;
  logic load;

  // Lets the new register value settle before the copy
  assign load = (reload && !reg_wr) || pend_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      duty_buffer_q <= DUTY_RST;
      period_buffer_q <= PERIOD_RST;
    end else begin
      pend_q <= reload && reg_wr;
      if (load) begin
        duty_buffer_q <= duty_reg;
        period_buffer_q <= period_reg;
      end
    end
  end

  AST_BUF_LOAD: assert property (@(posedge clk) disable iff (rst)
    (reload && !reg_wr) |=> (duty_buffer_q == $past(duty_reg)) &&
    (period_buffer_q == $past(period_reg)))
    else $error("Buffers not reloaded after clear");
endmodule // pxt_buf

//--- logic/pxt_trigger.sv
/*
  External trigger start/stop/clear and emergency stop for a PWM pair,
  with a minimal counter and duty/period compare, reached over APB.
  Assumes trigger pins are asynchronous and the APB master is on MCLK.
*/
`timescale 1ns/1ps
module pxt_trigger (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EVENT_INPUT_A,
  input wire logic EVENT_INPUT_B,
  output logic PWM_OUT_A,
  output logic PWM_OUT_B,
  output logic PWM_IRQ
);
  import pxt_pkg::*;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0] duty_reg_q;
  logic [15:0] period_reg_q;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic reg_wr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign mapped = hit(PADDR, CTRL_OFS) || hit(PADDR, DUTY_OFS) ||
    hit(PADDR, PERIOD_OFS) || hit(PADDR, STATUS_OFS) ||
    hit(PADDR, SDFLAG_OFS) || hit(PADDR, BUF_OFS);
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign reg_wr = wr_en && (hit(PADDR, DUTY_OFS) || hit(PADDR, PERIOD_OFS));

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= CTRL_RST;
      duty_reg_q <= DUTY_RST;
      period_reg_q <= PERIOD_RST;
    end else if (wr_en) begin
      if (hit(PADDR, CTRL_OFS)) begin
        ctrl_q <= PWDATA[CTRL_W-1:0];
      end
      if (hit(PADDR, DUTY_OFS)) begin
        duty_reg_q <= PWDATA[15:0];
      end
      if (hit(PADDR, PERIOD_OFS)) begin
        period_reg_q <= PWDATA[15:0];
      end
    end
  end

  logic run_bit;
  logic coupled_mode;
  logic [1:0] clk_src;
  logic [1:0] trig_mode;
  logic trig_input_select;
  logic [1:0] trig_polarity;
  logic clear_inhibit;
  logic [1:0] shutdown_edge;

  assign run_bit = ctrl_q[RUN_BIT];
  assign coupled_mode = ctrl_q[COUPLED_BIT];
  assign clk_src = ctrl_q[CLK_SRC_LSB +: 2];
  assign trig_mode = ctrl_q[TRIG_MODE_LSB +: 2];
  assign trig_input_select = ctrl_q[TRIG_SEL_BIT];
  assign trig_polarity = ctrl_q[TRIG_POL_LSB +: 2];
  assign clear_inhibit = ctrl_q[CLR_INH_BIT];
  assign shutdown_edge = ctrl_q[SD_EDGE_LSB +: 2];

  // ----------------------------------------
  // Sampling clock and input filter
  // ----------------------------------------
  logic [TICK_W-1:0] tick_cnt_q;
  logic [TICK_W-1:0] tick_last;
  logic tick;

  // Slow rate unless the fast oscillator is the counting source
  assign tick_last = (clk_src == CLK_SRC_FAST) ?
    TICK_W'(FAST_SAMPLE_CYC - 1) : TICK_W'(SLOW_SAMPLE_CYC - 1);
  assign tick = (tick_cnt_q >= tick_last);

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;

  // Both pins are filtered so switching the select causes no false edge
  pxt_filter u_filt_a (
    .clk(MCLK),
    .rst(RST),
    .pin(EVENT_INPUT_A),
    .tick(tick),
    .level_q(lvl[0]),
    .rise_q(rise[0]),
    .fall_q(fall[0])
  );

  pxt_filter u_filt_b (
    .clk(MCLK),
    .rst(RST),
    .pin(EVENT_INPUT_B),
    .tick(tick),
    .level_q(lvl[1]),
    .rise_q(rise[1]),
    .fall_q(fall[1])
  );

  logic in_lvl;
  logic in_rise;
  logic in_fall;
  assign in_lvl = lvl[trig_input_select];
  assign in_rise = rise[trig_input_select];
  assign in_fall = fall[trig_input_select];

  // ----------------------------------------
  // Trigger decode
  // ----------------------------------------
  logic pol_ok;
  logic start_lvl;
  logic start_edge;
  logic stop_edge;
  logic out_flag_q;
  logic gate_q;
  logic shutdown_flag_q;

  assign pol_ok = (trig_polarity == POL_RISE) ||
    (trig_polarity == POL_FALL);
  assign start_lvl = (trig_polarity == POL_RISE) ? in_lvl : !in_lvl;
  assign start_edge = pol_ok &&
    ((trig_polarity == POL_RISE) ? in_rise : in_fall);
  assign stop_edge = pol_ok &&
    ((trig_polarity == POL_RISE) ? in_fall : in_rise);

  // Edge-armed gate for mode 10
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      gate_q <= 1'b0;
    end else if (!run_bit || trig_mode != MODE_EXT) begin
      gate_q <= 1'b0;
    end else if (start_edge) begin
      gate_q <= 1'b1;
    end else if (stop_edge) begin
      gate_q <= 1'b0;
    end
  end

  logic cnt_en;
  logic ext_clear;

  always_comb begin
    cnt_en = 1'b0;
    ext_clear = 1'b0;
    unique case (trig_mode)
      MODE_SW: begin
        cnt_en = run_bit;
      end
      MODE_SW_EXT: begin
        // Invalid polarity leaves pure software control
        cnt_en = run_bit && (!pol_ok || start_lvl);
        ext_clear = run_bit && stop_edge;
      end
      MODE_EXT: begin
        cnt_en = gate_q;
        ext_clear = run_bit && stop_edge;
      end
      MODE_CLR: begin
        cnt_en = run_bit;
        ext_clear = start_edge && !(clear_inhibit && out_flag_q);
      end
    endcase
  end

  // ----------------------------------------
  // Emergency stop
  // ----------------------------------------
  logic sd_edge;
  logic sd_evt;
  logic sd_clr;

  always_comb begin
    unique case (shutdown_edge)
      SD_FALL: sd_edge = in_fall;
      SD_RISE: sd_edge = in_rise;
      SD_BOTH: sd_edge = in_rise || in_fall;
      default: sd_edge = 1'b0;
    endcase
  end

  assign sd_evt = coupled_mode && sd_edge;
  assign sd_clr = wr_en && hit(PADDR, SDFLAG_OFS) && PWDATA[SD_FLAG_BIT];

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      shutdown_flag_q <= 1'b0;
      PWM_IRQ <= 1'b0;
    end else begin
      // A new event wins over a clear in the same cycle
      if (sd_evt) begin
        shutdown_flag_q <= 1'b1;
      end else if (sd_clr) begin
        shutdown_flag_q <= 1'b0;
      end
      PWM_IRQ <= sd_evt;
    end
  end

  // ----------------------------------------
  // Counter, compare and outputs
  // ----------------------------------------
  logic [15:0] cnt_q;
  logic [15:0] duty_buffer;
  logic [15:0] period_buffer;
  logic period_hit;
  logic reload;
  logic running;

  // Counting stays held off until software clears the shutdown flag
  assign running = cnt_en && !shutdown_flag_q && !sd_evt;
  assign period_hit = running && (cnt_q == period_buffer);
  assign reload = ext_clear || period_hit;

  pxt_buf u_buf (
    .clk(MCLK),
    .rst(RST),
    .reload(reload),
    .reg_wr(reg_wr),
    .duty_reg(duty_reg_q),
    .period_reg(period_reg_q),
    .duty_buffer_q(duty_buffer),
    .period_buffer_q(period_buffer)
  );

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt_q <= 16'h0000;
    end else if (sd_evt || ext_clear || period_hit) begin
      cnt_q <= 16'h0000;
    end else if (running) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      out_flag_q <= 1'b1;
    end else if (sd_evt || shutdown_flag_q) begin
      out_flag_q <= 1'b0;
    end else if (ext_clear || period_hit) begin
      out_flag_q <= 1'b1;
    end else if (running && cnt_q == duty_buffer) begin
      out_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PWM_OUT_A <= 1'b0;
      PWM_OUT_B <= 1'b0;
    end else begin
      PWM_OUT_A <= out_flag_q;
      PWM_OUT_B <= coupled_mode && out_flag_q;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    PRDATA = 32'h0000_0000;
    if (rd_en) begin
      if (hit(PADDR, CTRL_OFS)) begin
        PRDATA = {{(32-CTRL_W){1'b0}}, ctrl_q};
      end else if (hit(PADDR, DUTY_OFS)) begin
        PRDATA = {16'h0000, duty_reg_q};
      end else if (hit(PADDR, PERIOD_OFS)) begin
        PRDATA = {16'h0000, period_reg_q};
      end else if (hit(PADDR, STATUS_OFS)) begin
        PRDATA[15:0] = cnt_q;
        PRDATA[ST_FLAG_BIT] = out_flag_q;
        PRDATA[ST_RUNNING_BIT] = running;
      end else if (hit(PADDR, SDFLAG_OFS)) begin
        PRDATA[SD_FLAG_BIT] = shutdown_flag_q;
      end else if (hit(PADDR, BUF_OFS)) begin
        PRDATA = {period_buffer, duty_buffer};
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_sd_edge;
    sd_evt;
  endsequence
  sequence s_sd_effect;
    shutdown_flag_q && PWM_IRQ && cnt_q == 16'h0000 && !out_flag_q
      ##1 !PWM_OUT_A && !PWM_OUT_B;
  endsequence

  AST_SW_MODE: assert property (@(posedge MCLK) disable iff (RST)
    (trig_mode == MODE_SW) |-> (cnt_en == run_bit))
    else $error("Software mode not following run bit");

  AST_M01_HOLD: assert property (@(posedge MCLK) disable iff (RST)
    (trig_mode == MODE_SW_EXT && pol_ok && !start_lvl) |-> !cnt_en)
    else $error("Counter ran at stop level");

  AST_STOP_CLEAR: assert property (@(posedge MCLK) disable iff (RST)
    ext_clear |=> (cnt_q == 16'h0000))
    else $error("External stop did not clear counter");

  AST_M10_NORUN: assert property (@(posedge MCLK) disable iff (RST)
    (trig_mode == MODE_EXT && !run_bit) |=> !gate_q)
    else $error("Edge armed counter with run bit low");

  AST_CLR_INH: assert property (@(posedge MCLK) disable iff (RST)
    (trig_mode == MODE_CLR && clear_inhibit && out_flag_q) |-> !ext_clear)
    else $error("External clear accepted while inhibited");

  AST_SD_COUPLED: assert property (@(posedge MCLK) disable iff (RST)
    !coupled_mode |-> !sd_evt)
    else $error("Emergency stop outside coupled mode");

  AST_SD_EFFECT: assert property (@(posedge MCLK) disable iff (RST)
    s_sd_edge |=> s_sd_effect)
    else $error("Emergency stop effects missing");

  AST_SD_W1C: assert property (@(posedge MCLK) disable iff (RST)
    (sd_clr && !sd_evt) |=> !shutdown_flag_q)
    else $error("Shutdown flag not cleared by write of one");

  AST_SD_HOLD: assert property (@(posedge MCLK) disable iff (RST)
    (shutdown_flag_q && !sd_clr) |=> shutdown_flag_q)
    else $error("Shutdown flag dropped without write of one");

  AST_SD_RISE: assert property (@(posedge MCLK) disable iff (RST)
    (coupled_mode && shutdown_edge == SD_RISE && in_fall) |-> !sd_evt)
    else $error("Rising-edge stop fired on falling edge");

  AST_BAD_POL: assert property (@(posedge MCLK) disable iff (RST)
    !pol_ok |-> !start_edge && !stop_edge)
    else $error("Undefined polarity produced an event");
endmodule // pxt_trigger

//--- tb/pxt_pins.sv
/*
  Model of the two external trigger pins that sit beside the PWM pair.
  Assumes the bench calls its tasks from one process, clocked by clk.
*/
`timescale 1ns/1ps
module pxt_pins (
  input wire logic clk,
  output logic ev_a,
  output logic ev_b
);
  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  initial begin
    ev_a = 1'b0;
    ev_b = 1'b0;
  end

  // Each level is held for a whole bench wait, well past one sample
  task automatic drive(input logic sel, input logic lvl);
    @(posedge clk);
    if (sel) begin
      ev_b <= lvl;
    end else begin
      ev_a <= lvl;
    end
  endtask

  // Deliberately short pulse, only used to probe the noise filter
  task automatic pulse(input logic sel, input logic lvl, input int n);
    drive(sel, lvl);
    repeat (n) @(posedge clk);
    drive(sel, !lvl);
  endtask
endmodule // pxt_pins

//--- tb/tb_pxt_trigger.sv
/*
  Self-checking bench for the external trigger and emergency stop block.
  Assumes a zero-wait APB slave and the fast sampling figures of pxt_pkg.
*/
`timescale 1ns/1ps
module tb_pxt_trigger;
  import pxt_pkg::*;
  localparam int WF = 80;
  logic MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic rerr, ev_a, ev_b, out_a, out_b, irq;
  int num_errors = 0;
  int n_tests = 0;
  int irq_n = 0;

  pxt_trigger dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .EVENT_INPUT_A(ev_a),
    .EVENT_INPUT_B(ev_b), .PWM_OUT_A(out_a), .PWM_OUT_B(out_b),
    .PWM_IRQ(irq));
  pxt_pins pins (.clk(MCLK), .ev_a(ev_a), .ev_b(ev_b));

  // ----------------------------------------
  // Clock, interrupt pulse count, watchdog
  // ----------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    if (irq === 1'b1) begin
      irq_n <= irq_n + 1;
    end
  end

  initial begin
    repeat (60000) @(posedge MCLK);
    num_errors++;
    results();
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results();
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic chk2(input string nm, input logic [1:0] seen,
                      input logic [1:0] exp);
    chk(nm, {30'h0, seen}, {30'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  task automatic run_is(input logic v);
    rd(STATUS_OFS);
    chk("counting", {31'h0, rdat[ST_RUNNING_BIT]}, {31'h0, v});
  endtask

  // Trigger stop: counter parked at zero and not counting
  task automatic stopped_clear();
    rd(STATUS_OFS);
    chk("stop_clr", {15'h0, rdat[ST_RUNNING_BIT], rdat[15:0]}, 32'h0);
  endtask

  function automatic logic [31:0] cfg(input logic run, input logic cpl,
    input logic [1:0] cs, input logic [1:0] md, input logic sel,
    input logic [1:0] pol, input logic inh, input logic [1:0] sd);
    cfg = 32'h0;
    cfg[RUN_BIT] = run;
    cfg[COUPLED_BIT] = cpl;
    cfg[CLK_SRC_LSB +: 2] = cs;
    cfg[TRIG_MODE_LSB +: 2] = md;
    cfg[TRIG_SEL_BIT] = sel;
    cfg[TRIG_POL_LSB +: 2] = pol;
    cfg[CLR_INH_BIT] = inh;
    cfg[SD_EDGE_LSB +: 2] = sd;
  endfunction

  // One emergency event: flag, outputs off, counter held at zero
  task automatic emg(input logic lvl, input int n_irq);
    wr(SDFLAG_OFS, 32'h1);
    pins.drive(1'b0, lvl);
    wt(WF);
    rd(SDFLAG_OFS);
    chk("sd_flag", rdat, 32'h1);
    rd(STATUS_OFS);
    chk("sd_stat", {14'h0, rdat[ST_RUNNING_BIT:0]}, 32'h0);
    chk("outs", {30'h0, out_a, out_b}, 32'h0);
    chk("irq_n", irq_n, n_irq);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    wt(8);
    RST <= 1'b0;
    rd(CTRL_OFS);
    chk("ctrl_rst", rdat, {20'h0, CTRL_RST});
    rd(PERIOD_OFS);
    chk("per_rst", rdat, {16'h0, PERIOD_RST});
    rd(8'h18);
    chk("unmapped", {rerr, rdat[30:0]}, {1'b1, 31'h0});
    wr(BUF_OFS, 32'h0000_abcd);
    rd(BUF_OFS);
    chk("buf_ro", rdat, {PERIOD_RST, DUTY_RST});
    // Mode 00: pin toggles change nothing
    wr(CTRL_OFS, cfg(1, 0, CLK_SRC_FAST, MODE_SW, 0, POL_RISE, 0, 0));
    pins.drive(1'b0, 1'b1);
    wt(WF);
    pins.drive(1'b0, 1'b0);
    wt(WF);
    rd(STATUS_OFS);
    chk2("sw_run", {rdat[ST_RUNNING_BIT], rdat[15:0] > 16'd150}, 2'b11);
    chk("out_b", {31'h0, out_b}, 32'h0);
    // Mode 01, rising start: pin low holds the count
    wr(CTRL_OFS, cfg(1, 0, CLK_SRC_FAST, MODE_SW_EXT, 0, POL_RISE, 0, 0));
    wt(WF);
    run_is(1'b0);
    pins.pulse(1'b0, 1'b1, 8);
    wt(WF);
    run_is(1'b0);
    pins.drive(1'b0, 1'b1);
    wt(WF);
    run_is(1'b1);
    wt(WF);
    run_is(1'b1);
    pins.drive(1'b0, 1'b0);
    wt(WF);
    stopped_clear();
    // Mode 01, falling start: low is the start level
    wr(CTRL_OFS, cfg(1, 0, CLK_SRC_FAST, MODE_SW_EXT, 0, POL_FALL, 0, 0));
    wt(WF);
    run_is(1'b1);
    pins.drive(1'b0, 1'b1);
    wt(WF);
    stopped_clear();
    pins.drive(1'b0, 1'b0);
    wt(WF);
    // Undefined polarities leave software in charge
    for (int p = 0; p < 4; p += 3) begin
      wr(CTRL_OFS, cfg(1, 0, CLK_SRC_FAST, MODE_SW_EXT, 0, p[1:0], 0, 0));
      wt(WF);
      run_is(1'b1);
      pins.drive(1'b0, !ev_a);
      wt(WF);
      run_is(1'b1);
    end
    // Slow sampling is far slower than the fast one
    wr(CTRL_OFS, cfg(1, 0, 2'b00, MODE_SW_EXT, 0, POL_RISE, 0, 0));
    pins.drive(1'b0, 1'b1);
    wt(WF);
    run_is(1'b0);
    wt(4 * SLOW_SAMPLE_CYC);
    run_is(1'b1);
    pins.drive(1'b0, 1'b0);
    wr(CTRL_OFS, cfg(0, 0, CLK_SRC_FAST, MODE_SW, 0, POL_RISE, 0, 0));
    wt(2 * WF);
    // Mode 10 on the second pin
    wr(CTRL_OFS, cfg(0, 0, CLK_SRC_FAST, MODE_EXT, 1, POL_RISE, 0, 0));
    pins.drive(1'b1, 1'b1);
    wt(WF);
    run_is(1'b0);
    pins.drive(1'b1, 1'b0);
    wt(WF);
    wr(CTRL_OFS, cfg(1, 0, CLK_SRC_FAST, MODE_EXT, 1, POL_RISE, 0, 0));
    wt(4);
    run_is(1'b0);
    pins.drive(1'b1, 1'b1);
    wt(WF);
    run_is(1'b1);
    pins.drive(1'b1, 1'b0);
    wt(WF);
    stopped_clear();
    // Mode 11: edge clears and reloads; register writes reach the buffers only at a clear or a period match
    wr(CTRL_OFS, cfg(1, 0, CLK_SRC_FAST, MODE_CLR, 0, POL_RISE, 0, 0));
    wr(DUTY_OFS, 32'h0000_1234);
    wr(PERIOD_OFS, 32'h0000_5678);
    wt(200);
    rd(BUF_OFS);
    chk("buf_old", rdat, {PERIOD_RST, DUTY_RST});
    pins.drive(1'b0, 1'b1);
    wt(WF);
    rd(BUF_OFS);
    chk("buf_new", rdat, 32'h5678_1234);
    rd(STATUS_OFS);
    chk2("clr", {rdat[ST_RUNNING_BIT], rdat[15:0] < 16'd100}, 2'b11);
    pins.drive(1'b0, 1'b0);
    wt(WF);
    wr(CTRL_OFS, cfg(1, 0, CLK_SRC_FAST, MODE_CLR, 0, POL_RISE, 1, 0));
    pins.drive(1'b0, 1'b1);
    wt(WF);
    rd(STATUS_OFS);
    chk2("inhib", {rdat[ST_FLAG_BIT], rdat[15:0] > 16'd150}, 2'b11);
    // Emergency stop: ignored when not coupled
    wr(CTRL_OFS, cfg(1, 0, CLK_SRC_FAST, MODE_SW, 0, POL_RISE, 0, SD_FALL));
    pins.drive(1'b0, 1'b0);
    wt(WF);
    rd(SDFLAG_OFS);
    chk("sd_uncpl", {rdat[30:0], irq_n[0]}, 32'h0);
    wr(CTRL_OFS, cfg(1, 1, CLK_SRC_FAST, MODE_SW, 0, POL_RISE, 0, SD_RISE));
    emg(1'b1, 1);
    wr(SDFLAG_OFS, 32'h0);
    rd(SDFLAG_OFS);
    chk("w0_keep", rdat, 32'h1);
    wr(SDFLAG_OFS, 32'h1);
    rd(SDFLAG_OFS);
    chk("w1_clr", rdat, 32'h0);
    // Rising-only select must ignore a falling edge
    pins.drive(1'b0, 1'b0);
    wt(WF);
    rd(SDFLAG_OFS);
    chk("rise_only", {rdat[30:0], irq_n[0]}, 32'h1);
    wr(CTRL_OFS, cfg(1, 1, CLK_SRC_FAST, MODE_SW, 0, POL_RISE, 0, SD_FALL));
    // Rising edge here must not count as a stop under falling select
    pins.drive(1'b0, 1'b1);
    wt(WF);
    emg(1'b0, 2);
    wr(CTRL_OFS, cfg(1, 1, CLK_SRC_FAST, MODE_SW, 0, POL_RISE, 0, SD_BOTH));
    emg(1'b1, 3);
    emg(1'b0, 4);
    results();
  end
endmodule // tb_pxt_trigger
